//--- inc/bssp_pkg.sv
// Shared constants for the split-port burst SRAM interface
package bssp_pkg;

  // ********************************************************
  // Burst and width constants
  // ********************************************************
  localparam int BURST_LEN   = 4;
  localparam int CNT_W       = 2;
  localparam int EDGE_HALVES = 2;
  localparam int DEF_DATA_W  = 36;
  localparam int DEF_ADDR_W  = 4;
  localparam int FIFO_DEPTH  = 16;
  localparam int SYNC_LEN    = 2;

  // Byte lane layout per data width
  localparam int W_ONE_LANE  = 9;
  localparam int W_FOUR_LANE = 36;
  localparam int LANES_ONE   = 1;
  localparam int LANES_TWO   = 2;
  localparam int LANES_FOUR  = 4;

  // ********************************************************
  // Read latency in half cycles of the input clock
  // ********************************************************
  localparam int LAT_PLL_ON  = 5;
  localparam int LAT_PLL_OFF = 2;
  localparam int QUEUE_LEN   = LAT_PLL_ON + EDGE_HALVES;

  function automatic int bssp_lanes(input int w);
    if (w == W_ONE_LANE) begin
      return LANES_ONE;
    end
    if (w == W_FOUR_LANE) begin
      return LANES_FOUR;
    end
    return LANES_TWO;
  endfunction

endpackage

//--- hw/bssp_sram_if.sv
// Split-port burst SRAM interface with its write FIFO
`timescale 1ns/10ps

// ********************************************************
// Show-ahead FIFO
// ********************************************************
module bssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } bssp_fifo_t;

  bssp_fifo_t s_reg;
  bssp_fifo_t s_next;
  logic       push;
  logic       pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + 1'b1;
  endfunction

  assign in_ready  = (s_reg.cnt != (PW + 1)'(DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data  = s_reg.mem[s_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = bump(s_reg.wp);
    end
    if (pop) begin
      s_next.rp = bump(s_reg.rp);
    end
    s_next.cnt = s_reg.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// How it works
// - Read and write addresses share one bus, one port taken per edge.
// - Every address names a group of four words moved as one burst.
// - Data moves on rising edges of the true and complement clocks only.
// - With the PLL select high read data starts 2.5 cycles on.
// - With the PLL select low read data starts one cycle on.
// - All synchronous inputs pass through input flops first.
// - Read data and its flag leave through output flops.
// - A read burst and a write burst may run at the same time.
// - Writes are committed to the array by an internal self-timed writer.
// - Each port starts only on its own active-low select.
// - The read-valid flag is high exactly while read words are shown.
// - Echo clocks follow the input clocks and travel with read data.
// - A read returns the newest write, even one not yet committed.
// - Word width is a build parameter of 9, 18 or 36 bits.
module bssp_sram_if
  import bssp_pkg::*;
#(
  parameter int DATA_W = DEF_DATA_W,
  parameter int ADDR_W = DEF_ADDR_W,
  parameter int DEPTH  = FIFO_DEPTH
)(
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        k_clk,
  input  wire logic                        k_n_clk,
  input  wire logic [ADDR_W-1:0]           addr,
  input  wire logic                        read_sel_n,
  input  wire logic                        write_sel_n,
  input  wire logic [DATA_W-1:0]           wdata,
  input  wire logic [bssp_lanes(DATA_W)-1:0] write_lane_n,
  input  wire logic                        pll_off_select,
  output logic      [DATA_W-1:0]           rdata,
  output logic                             read_valid_flag,
  output logic                             echo_clock,
  output logic                             echo_clock_n,
  output logic                             link_active
);
  localparam int LN = bssp_lanes(DATA_W);
  localparam int LW = DATA_W / LN;
  localparam int NADDR = 1 << ADDR_W;

  // ********************************************************
  // Types and state
  // ********************************************************
  typedef logic [DATA_W-1:0] bssp_word_t;

  typedef struct packed {
    logic [ADDR_W-1:0]                addr;
    logic [BURST_LEN-1:0][DATA_W-1:0] data;
    logic [BURST_LEN-1:0][LN-1:0]     lane_n;
  } bssp_ent_t;

  typedef struct packed {
    logic [NADDR-1:0][BURST_LEN-1:0][DATA_W-1:0] mem;
    logic [ADDR_W-1:0]                  a;
    logic                               rsel_n;
    logic                               wsel_n;
    logic [DATA_W-1:0]                  d;
    logic [LN-1:0]                      ln;
    logic                               rd_last;
    logic [CNT_W-1:0]                   wr_beat;
    logic [ADDR_W-1:0]                  wr_addr;
    logic [EDGE_HALVES-1:0][DATA_W-1:0] wr_d;
    logic [EDGE_HALVES-1:0][LN-1:0]     wr_ln;
    logic [QUEUE_LEN-1:0]               q_v;
    logic [QUEUE_LEN-1:0][DATA_W-1:0]   q_d;
    logic                               rise_v;
    logic [DATA_W-1:0]                  rise_d;
    logic                               fall_v;
    logic [DATA_W-1:0]                  fall_d;
    logic                               pll_m;
    logic                               pll_s;
    logic                               busy;
  } bssp_k_t;

  typedef struct packed {
    logic [DATA_W-1:0] d;
    logic [LN-1:0]     ln;
    logic              out_v;
    logic [DATA_W-1:0] out_d;
  } bssp_kn_t;

  typedef struct packed {
    logic s0;
    logic s1;
  } bssp_c_t;

  bssp_k_t                     k_reg;
  bssp_k_t                     k_next;
  bssp_kn_t                    kn_reg;
  bssp_kn_t                    kn_next;
  bssp_c_t                     c_reg;
  bssp_c_t                     c_next;
  logic [SYNC_LEN-1:0]         rst_sync;
  logic                        k_rst_n;
  logic                        rd_go;
  logic                        wr_go;
  logic                        f_in_valid;
  logic                        f_in_ready;
  logic                        f_out_valid;
  logic                        f_out_ready;
  bssp_ent_t                   f_in;
  bssp_ent_t                   f_out;
  logic [BURST_LEN-1:0][DATA_W-1:0] rd_w;

  function automatic bssp_word_t merge(input bssp_word_t o,
                                       input bssp_word_t n,
                                       input logic [LN-1:0] ln);
    bssp_word_t r;
    r = o;
    for (int l = 0; l < LN; l++) begin
      if (!ln[l]) begin
        r[l*LW +: LW] = n[l*LW +: LW];
      end
    end
    return r;
  endfunction

  // ********************************************************
  // Link reset and write FIFO
  // ********************************************************
  always_ff @(posedge k_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= '0;
    end else begin
      rst_sync <= {rst_sync[SYNC_LEN-2:0], 1'b1};
    end
  end
  assign k_rst_n = rst_sync[SYNC_LEN-1];

  assign f_in = '{addr:   k_reg.wr_addr,
                  data:   {kn_reg.d, k_reg.d, k_reg.wr_d},
                  lane_n: {kn_reg.ln, k_reg.ln, k_reg.wr_ln}};
  assign f_in_valid = (k_reg.wr_beat != '0);

  bssp_fifo #(
    .WIDTH ($bits(bssp_ent_t)),
    .DEPTH (DEPTH)
  ) u_wr_fifo (
    .clk       (k_clk),
    .rst_n     (k_rst_n),
    .in_valid  (f_in_valid),
    .in_data   (f_in),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out)
  );

  // ********************************************************
  // Link logic on the true input clock
  // ********************************************************
  always_comb begin
    bssp_word_t w;
    int         ins;
    w = '0;
    ins = 0;
    k_next = k_reg;
    k_next.a = addr;
    k_next.rsel_n = read_sel_n;
    k_next.wsel_n = write_sel_n;
    k_next.d = wdata;
    k_next.ln = write_lane_n;
    k_next.pll_m = pll_off_select;
    k_next.pll_s = k_reg.pll_m;
    rd_go = !k_reg.rsel_n && !k_reg.rd_last;
    wr_go = !k_reg.wsel_n && !rd_go && (k_reg.wr_beat == '0) &&
            f_in_ready;
    k_next.rd_last = rd_go;
    if (wr_go) begin
      k_next.wr_addr = k_reg.a;
      k_next.wr_d = {kn_reg.d, k_reg.d};
      k_next.wr_ln = {kn_reg.ln, k_reg.ln};
    end
    if (wr_go || k_reg.wr_beat != '0) begin
      k_next.wr_beat = k_reg.wr_beat + CNT_W'(EDGE_HALVES);
    end
    for (int j = 0; j < BURST_LEN; j++) begin
      w = k_reg.mem[k_reg.a][CNT_W'(j)];
      if (f_out_valid && f_out.addr == k_reg.a) begin
        w = merge(w, f_out.data[j], f_out.lane_n[j]);
      end
      if (f_in_valid && k_reg.wr_addr == k_reg.a) begin
        w = merge(w, f_in.data[j], f_in.lane_n[j]);
      end
      rd_w[j] = w;
    end
    f_out_ready = !rd_go;
    if (f_out_valid && f_out_ready) begin
      for (int j = 0; j < BURST_LEN; j++) begin
        k_next.mem[f_out.addr][j] =
          merge(k_reg.mem[f_out.addr][j], f_out.data[j],
                f_out.lane_n[j]);
      end
    end
    for (int i = 0; i < QUEUE_LEN; i++) begin
      if (i + EDGE_HALVES < QUEUE_LEN) begin
        k_next.q_v[i] = k_reg.q_v[i+EDGE_HALVES];
        k_next.q_d[i] = k_reg.q_d[i+EDGE_HALVES];
      end else begin
        k_next.q_v[i] = 1'b0;
        k_next.q_d[i] = '0;
      end
    end
    // long latency with PLL select high
    // short latency with PLL select low
    ins = k_reg.pll_s ? LAT_PLL_ON - EDGE_HALVES
                      : LAT_PLL_OFF - EDGE_HALVES;
    if (rd_go) begin
      for (int j = 0; j < BURST_LEN; j++) begin
        k_next.q_v[ins+j] = 1'b1;
        k_next.q_d[ins+j] = rd_w[j];
      end
    end
    k_next.rise_v = k_next.q_v[0];
    k_next.rise_d = k_next.q_d[0];
    k_next.fall_v = k_next.q_v[1];
    k_next.fall_d = k_next.q_d[1];
    k_next.busy = (|k_next.q_v) || (k_next.wr_beat != '0) ||
                  f_out_valid;
  end

  always_ff @(posedge k_clk or negedge k_rst_n) begin
    if (!k_rst_n) begin
      k_reg <= '0;
      k_reg.rsel_n <= 1'b1;
      k_reg.wsel_n <= 1'b1;
      k_reg.ln <= '1;
    end else begin
      k_reg <= k_next;
    end
  end

  // ********************************************************
  // Link logic on the complement input clock
  // ********************************************************
  always_comb begin
    kn_next = kn_reg;
    kn_next.d = wdata;
    kn_next.ln = write_lane_n;
    kn_next.out_v = k_reg.fall_v;
    kn_next.out_d = k_reg.fall_d;
  end

  always_ff @(posedge k_n_clk or negedge k_rst_n) begin
    if (!k_rst_n) begin
      kn_reg <= '0;
      kn_reg.ln <= '1;
    end else begin
      kn_reg <= kn_next;
    end
  end

  // ********************************************************
  // Pins and system side
  // ********************************************************
  // DDR output select
  assign rdata = k_clk ? k_reg.rise_d : kn_reg.out_d;
  assign read_valid_flag = k_clk ? k_reg.rise_v : kn_reg.out_v;
  assign echo_clock = k_clk;
  assign echo_clock_n = k_n_clk;

  always_comb begin
    c_next = c_reg;
    c_next.s0 = k_reg.busy;
    c_next.s1 = c_reg.s0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end
  assign link_active = c_reg.s1;
endmodule

//--- dv/bssp_sram_props.sv
// Pin checks for the burst SRAM interface
`timescale 1ns/10ps
module bssp_props #(
  parameter int DATA_W = 36
)(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              k_clk,
  input wire logic              k_n_clk,
  input wire logic              read_sel_n,
  input wire logic              pll_off_select,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              read_valid_flag,
  input wire logic              echo_clock,
  input wire logic              echo_clock_n,
  input wire logic              link_active
);
  // ********************************************************
  // Read accept tracking
  // ********************************************************
  logic rd_acc_reg;
  logic acc;
  assign acc = !read_sel_n && !rd_acc_reg;
  always_ff @(posedge k_clk or negedge resetn) begin
    if (!resetn) begin
      rd_acc_reg <= 1'b0;
    end else begin
      rd_acc_reg <= acc;
    end
  end
  a_lat_short: assert property (
    @(posedge k_clk) disable iff (!resetn)
    acc && !pll_off_select |-> ##2 read_valid_flag [*2])
    else $error("short latency read word missing");
  a_lat_long: assert property (
    @(posedge k_clk) disable iff (!resetn)
    acc && pll_off_select |-> ##3 read_valid_flag [*2])
    else $error("long latency read word missing");
  a_early_short: assert property (
    @(posedge k_clk) disable iff (!resetn)
    acc && !pll_off_select && !$past(acc, 2) |=> !read_valid_flag)
    else $error("short latency read word too early");
  a_early_long: assert property (
    @(posedge k_clk) disable iff (!resetn)
    acc && pll_off_select && !$past(acc, 2) |-> ##2 !read_valid_flag)
    else $error("long latency read word too early");
  a_flag_has_cause: assert property (
    @(posedge k_clk) disable iff (!resetn)
    read_valid_flag |-> $past(acc, 2) || $past(acc, 3) || $past(acc, 4))
    else $error("read valid without accepted read");
  a_echo_true: assert property (
    @(posedge clk) disable iff (!resetn) echo_clock == k_clk)
    else $error("echo clock does not follow true clock");
  a_echo_comp: assert property (
    @(posedge clk) disable iff (!resetn) echo_clock_n == k_n_clk)
    else $error("echo clock does not follow complement clock");
  a_reset_quiet: assert property (
    @(posedge clk) !resetn |-> rdata == '0 && !read_valid_flag
    && !link_active)
    else $error("outputs not quiet in reset");
  c_short: cover property (@(posedge k_clk) acc && !pll_off_select);
  c_long: cover property (@(posedge k_clk) acc && pll_off_select);
  c_link: cover property (@(posedge clk) $rose(link_active));
endmodule

bind bssp_sram_if bssp_props #(.DATA_W(DATA_W)) u_props (
  .clk(clk), .resetn(resetn), .k_clk(k_clk), .k_n_clk(k_n_clk),
  .read_sel_n(read_sel_n), .pll_off_select(pll_off_select),
  .rdata(rdata), .read_valid_flag(read_valid_flag),
  .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
  .link_active(link_active));

//--- dv/bssp_host.sv
// Host controller model driving the burst SRAM link
`timescale 1ns/10ps
module bssp_host #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 4,
  parameter int LN     = 4
)(
  output logic                  k_clk,
  output logic                  k_n_clk,
  output logic      [ADDR_W-1:0] addr,
  output logic                  read_sel_n,
  output logic                  write_sel_n,
  output logic      [DATA_W-1:0] wdata,
  output logic      [LN-1:0]     write_lane_n,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              read_valid_flag,
  input  wire logic              echo_clock,
  input  wire logic              echo_clock_n
);
  // ********************************************************
  // Free running input clock pair
  // ********************************************************
  initial begin
    k_clk = 1'b0;
    addr = '0;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    wdata = '0;
    write_lane_n = '1;
  end
  always #7.5 k_clk = ~k_clk;
  assign k_n_clk = ~k_clk;
  task automatic write_burst(input logic [ADDR_W-1:0] a,
      input logic [4*DATA_W-1:0] w, input logic [4*LN-1:0] m);
    @(posedge k_clk);
    write_sel_n <= 1'b0;
    addr <= a;
    wdata <= w[0 +: DATA_W];
    write_lane_n <= m[0 +: LN];
    @(posedge k_clk);
    for (int i = 1; i < 4; i++) begin
      write_sel_n <= 1'b1;
      wdata <= w[i*DATA_W +: DATA_W];
      write_lane_n <= m[i*LN +: LN];
      @(posedge k_clk or posedge k_n_clk);
    end
    wdata <= ~wdata;
    write_lane_n <= '1;
  endtask
  task automatic read_burst(input logic [ADDR_W-1:0] a,
      output logic [4*DATA_W-1:0] r, output int lat);
    int h;
    int n;
    int first;
    r = '0;
    @(posedge k_clk);
    read_sel_n <= 1'b0;
    addr <= a;
    @(posedge k_clk);
    read_sel_n <= 1'b1;
    addr <= ~a;
    // Step past the accept edge so its echo is never counted
    #1;
    h = 0;
    n = 0;
    first = -1;
    while (n < 4 && h < 16) begin
      @(posedge echo_clock or posedge echo_clock_n);
      h++;
      #1;
      if (read_valid_flag === 1'b1) begin
        if (n == 0) first = h;
        r[n*DATA_W +: DATA_W] = rdata;
        n++;
      end
    end
    lat = (n == 4 && h == first + 3) ? first : -1;
  endtask
endmodule

//--- dv/bssp_tb.sv
// Self-checking bench for the burst SRAM interface
`timescale 1ns/10ps
module testbench;
  import bssp_pkg::*;
  localparam int DW = 36;
  localparam int AW = 4;
  localparam int LN = bssp_lanes(DW);
  localparam int LW = DW / LN;
  localparam int BW = 4 * DW;
  logic          clk = 1'b0;
  logic          resetn;
  logic          pll_off_select;
  logic          k_clk;
  logic          k_n_clk;
  logic [AW-1:0] addr;
  logic          read_sel_n;
  logic          write_sel_n;
  logic [DW-1:0] wdata;
  logic [LN-1:0] write_lane_n;
  logic [DW-1:0] rdata;
  logic          read_valid_flag;
  logic          echo_clock;
  logic          echo_clock_n;
  logic          link_active;
  logic          seen_act = 1'b0;
  logic [BW-1:0] got;
  int            lat;
  int            mismatches = 0;
  int            n_tests = 0;
  always #2 clk = ~clk;
  bssp_sram_if #(.DATA_W(DW), .ADDR_W(AW), .DEPTH(FIFO_DEPTH)) dut (
    .clk(clk), .resetn(resetn), .k_clk(k_clk), .k_n_clk(k_n_clk),
    .addr(addr), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
    .wdata(wdata), .write_lane_n(write_lane_n),
    .pll_off_select(pll_off_select), .rdata(rdata),
    .read_valid_flag(read_valid_flag), .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n), .link_active(link_active));
  bssp_host #(.DATA_W(DW), .ADDR_W(AW), .LN(LN)) host (
    .k_clk(k_clk), .k_n_clk(k_n_clk), .addr(addr),
    .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .wdata(wdata),
    .write_lane_n(write_lane_n), .rdata(rdata),
    .read_valid_flag(read_valid_flag), .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n));
  always @(posedge clk) begin
    if (link_active === 1'b1) seen_act <= 1'b1;
  end
  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [BW-1:0] mk(input logic [7:0] s);
    logic [BW-1:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*DW +: DW] = {4{1'b0, s + 8'(i)}};
    end
    return r;
  endfunction
  function automatic logic [BW-1:0] merge(input logic [BW-1:0] o,
      input logic [BW-1:0] n, input logic [4*LN-1:0] m);
    logic [BW-1:0] r;
    for (int i = 0; i < 4 * LN; i++) begin
      r[i*LW +: LW] = m[i] ? o[i*LW +: LW] : n[i*LW +: LW];
    end
    return r;
  endfunction
  task automatic chk_burst(string w, logic [BW-1:0] e, logic [BW-1:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic chk_num(string w, int e, int s);
    n_tests++;
    if (s != e) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", w, e, s);
    end
  endtask
  task automatic chk_bit(string w, logic e, logic s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", w, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    repeat (3) @(posedge clk);
    while (link_active !== 1'b0 && i < 200) begin
      @(posedge clk);
      i++;
    end
    if (i >= 200) begin
      mismatches++;
      end_of_test;
    end
  endtask
  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_reset;
    chk_bit("read valid", 1'b0, read_valid_flag);
    chk_burst("read data", '0, {4{rdata}});
    $display("t_reset done");
  endtask
  task automatic t_short;
    host.write_burst(4'h3, mk(8'h50), '0);
    host.read_burst(4'h3, got, lat);
    chk_burst("burst 3", mk(8'h50), got);
    chk_num("short latency", LAT_PLL_OFF, lat);
    wait_idle;
    chk_bit("link busy seen", 1'b1, seen_act);
    $display("t_short done");
  endtask
  task automatic t_lanes;
    host.write_burst(4'h3, mk(8'ha0), 16'ha5c3);
    host.read_burst(4'h3, got, lat);
    chk_burst("masked", merge(mk(8'h50), mk(8'ha0), 16'ha5c3), got);
    $display("t_lanes done");
  endtask
  task automatic t_long;
    @(posedge clk);
    pll_off_select <= 1'b1;
    repeat (6) @(posedge k_clk);
    host.read_burst(4'h3, got, lat);
    chk_num("long latency", LAT_PLL_ON, lat);
    chk_burst("long", merge(mk(8'h50), mk(8'ha0), 16'ha5c3), got);
    @(posedge clk);
    pll_off_select <= 1'b0;
    repeat (6) @(posedge k_clk);
    $display("t_long done");
  endtask
  task automatic t_conc;
    fork
      host.write_burst(4'h4, mk(8'hc0), '0);
      begin
        @(posedge k_clk);
        host.read_burst(4'h4, got, lat);
      end
    join
    chk_burst("overlap", mk(8'hc0), got);
    chk_num("overlap latency", LAT_PLL_OFF, lat);
    $display("t_conc done");
  endtask
  initial begin
    resetn = 1'b0;
    pll_off_select = 1'b0;
    repeat (12) @(posedge clk);
    t_reset;
    resetn <= 1'b1;
    repeat (5) @(posedge k_clk);
    t_short;
    t_lanes;
    t_long;
    t_conc;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule
